// ==== hdl/sdbl_defs.svh ====
// timing counts, geometry defaults and command codes for the bank legality block
// assumes a 125 MHz command clock shared with the issuing controller
`ifndef SDBL_DEFS_SVH
`define SDBL_DEFS_SVH

// ****************************************************
// clock and timing figures
// ****************************************************
`define SDBL_CLK_NS 8
`define SDBL_T_RP_NS 20
`define SDBL_T_RCD_NS 20
`define SDBL_T_RC_NS 66
// least times round up to whole cycles
`define SDBL_CYC(ns) (((ns) + `SDBL_CLK_NS - 1) / `SDBL_CLK_NS)
`define SDBL_RP_CYC `SDBL_CYC(`SDBL_T_RP_NS)
`define SDBL_RCD_CYC `SDBL_CYC(`SDBL_T_RCD_NS)
`define SDBL_RC_CYC `SDBL_CYC(`SDBL_T_RC_NS)
// already given in clocks
`define SDBL_MRD_CYC 2
`define SDBL_WR_CYC 2

// ****************************************************
// geometry defaults
// ****************************************************
`define SDBL_NBANK 4
`define SDBL_CL 3
`define SDBL_BL 4
`define SDBL_CNT_W 4

// ****************************************************
// command codes on {ras, cas, we} with select low
// ****************************************************
`define SDBL_CMD_NOP 3'h7
`define SDBL_CMD_ACT 3'h3
`define SDBL_CMD_RD 3'h5
`define SDBL_CMD_WR 3'h4
`define SDBL_CMD_PRE 3'h2
`define SDBL_CMD_REF 3'h1
`define SDBL_CMD_LMR 3'h0
`define SDBL_CMD_BST 3'h6

`endif

// ==== hdl/sdbl_pkg.sv ====
// state types shared by the bank tracker and the command decoder
// assumes nothing beyond a SystemVerilog tool
package sdbl_pkg;

    // ****************************************************
    // per-bank state, one-hot
    // ****************************************************
    typedef enum logic [7:0] {
        BANK_IDLE = 8'h01,
        BANK_ACTIVATING = 8'h02,
        BANK_ACTIVE = 8'h04,
        BANK_READ = 8'h08,
        BANK_WRITE = 8'h10,
        BANK_READ_AP = 8'h20,
        BANK_WRITE_AP = 8'h40,
        BANK_PRECHARGING = 8'h80
    } sdbl_bank_e;

    // ****************************************************
    // device-wide state, one-hot
    // ****************************************************
    typedef enum logic [3:0] {
        GLOB_NORMAL = 4'h1,
        GLOB_REFRESH = 4'h2,
        GLOB_MODE = 4'h4,
        GLOB_PRE_ALL = 4'h8
    } sdbl_glob_e;

endpackage : sdbl_pkg

// ==== hdl/sdbl_bank_if.sv ====
// per-bank command strobes from the decoder and the bank state back
// assumes one instance per bank, all on the block clock
`timescale 1ns/1ns
interface sdbl_bank_if;
    logic act;
    logic rd;
    logic wr;
    logic ap;
    logic pre;
    logic stop;
    sdbl_pkg::sdbl_bank_e state;

    modport ctrl (output act, output rd, output wr, output ap, output pre,
                  output stop, input state);
    modport bank (input act, input rd, input wr, input ap, input pre,
                  input stop, output state);
endinterface : sdbl_bank_if

// ==== hdl/sdbl_bank.sv ====
// one bank's state and its own timers
// assumes strobes are only raised for commands the decoder accepted
`timescale 1ns/1ns
`include "sdbl_defs.svh"
module sdbl_bank (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // decoder side
    sdbl_bank_if.bank bus
);
    localparam logic [`SDBL_CNT_W-1:0] RcdLoad = `SDBL_CNT_W'(`SDBL_RCD_CYC - 1);
    localparam logic [`SDBL_CNT_W-1:0] RpLoad = `SDBL_CNT_W'(`SDBL_RP_CYC - 1);
    localparam logic [`SDBL_CNT_W-1:0] WrLoad = `SDBL_CNT_W'(`SDBL_WR_CYC - 1);

    sdbl_pkg::sdbl_bank_e state_r;
    logic [`SDBL_CNT_W-1:0] cnt_r;
    logic apRun_r;
    logic wrRec_r;
    logic cntDone;

    // leaving one edge early makes the new state visible on the due edge
    assign cntDone = (cnt_r <= `SDBL_CNT_W'(1));
    assign bus.state = state_r;

    // ****************************************************
    // bank state machine
    // ****************************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= sdbl_pkg::BANK_IDLE;
            cnt_r <= '0;
            apRun_r <= 1'b0;
            wrRec_r <= 1'b0;
        end else begin
            if (cnt_r != '0) cnt_r <= cnt_r - `SDBL_CNT_W'(1);
            unique case (state_r)
                sdbl_pkg::BANK_IDLE: begin
                    // a precharge here changes nothing
                    if (bus.act) begin
                        state_r <= sdbl_pkg::BANK_ACTIVATING;
                        cnt_r <= RcdLoad;
                    end
                end
                sdbl_pkg::BANK_ACTIVATING: begin
                    if (cntDone) state_r <= sdbl_pkg::BANK_ACTIVE;
                end
                sdbl_pkg::BANK_ACTIVE, sdbl_pkg::BANK_READ,
                sdbl_pkg::BANK_WRITE: begin
                    apRun_r <= 1'b0;
                    wrRec_r <= 1'b0;
                    if (bus.pre) begin
                        state_r <= sdbl_pkg::BANK_PRECHARGING;
                        cnt_r <= RpLoad;
                    end else if (bus.rd) begin
                        state_r <= bus.ap ? sdbl_pkg::BANK_READ_AP
                                          : sdbl_pkg::BANK_READ;
                    end else if (bus.wr) begin
                        state_r <= bus.ap ? sdbl_pkg::BANK_WRITE_AP
                                          : sdbl_pkg::BANK_WRITE;
                    end else if (bus.stop) begin
                        state_r <= sdbl_pkg::BANK_ACTIVE;
                    end
                end
                sdbl_pkg::BANK_READ_AP: begin
                    // precharge starts when the burst ends or is cut
                    if (!apRun_r && bus.stop) begin
                        apRun_r <= 1'b1;
                        cnt_r <= RpLoad;
                    end else if (apRun_r && cntDone) begin
                        state_r <= sdbl_pkg::BANK_IDLE;
                        apRun_r <= 1'b0;
                    end
                end
                sdbl_pkg::BANK_WRITE_AP: begin
                    // write recovery from the cut, then row precharge
                    if (!apRun_r && bus.stop) begin
                        apRun_r <= 1'b1;
                        wrRec_r <= 1'b1;
                        cnt_r <= WrLoad;
                    end else if (apRun_r && wrRec_r && cntDone) begin
                        wrRec_r <= 1'b0;
                        cnt_r <= RpLoad;
                    end else if (apRun_r && cntDone) begin
                        state_r <= sdbl_pkg::BANK_IDLE;
                        apRun_r <= 1'b0;
                    end
                end
                sdbl_pkg::BANK_PRECHARGING: begin
                    if (cntDone) state_r <= sdbl_pkg::BANK_IDLE;
                end
                default: begin
                    state_r <= sdbl_pkg::BANK_IDLE;
                end
            endcase
        end
    end
endmodule : sdbl_bank

// ==== hdl/sdbl_legality.sv ====
// command decode, burst tracking and device-wide states for four banks
// assumes command pins are driven on this clock by the controller
`timescale 1ns/1ns
`include "sdbl_defs.svh"
// Functional notes
// - read with autoprecharge idles after precharge time
// - write with autoprecharge idles after write recovery, then precharge time
// - refresh lasts row cycle, then all idle
// - mode access lasts mode delay, then idle
// - precharge all lasts precharge time
// - burst terminate ends latest burst, any bank, unless it has autoprecharge (then refused)
// - precharge to idle bank acts as nop
// - decode select, row, column, write strobes
// - other bank accepts what its state allows
// - active only after activate delay, no burst
// - interrupted autoprecharge bank precharges concurrently
// - read cuts plain read after cas latency
// - write cuts plain read at once; mask early
// - read cuts plain write at once
// - write cuts plain write at once
// - read cuts autoprecharge read; precharge starts now
// - write cuts autoprecharge read; precharge starts now
// - read cuts autoprecharge write; recovery from read
// - write cuts autoprecharge write; recovery from write
// - idle after precharge; idle banks accept activate
module sdbl_legality #(
    parameter int CasLatency = `SDBL_CL,
    parameter int BurstLen = `SDBL_BL
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // command pins
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [1:0] bankAddr,
    input wire logic autoPre,
    // state view
    output logic [31:0] bankStates,
    output logic [3:0] globalState,
    output logic allIdle,
    output logic cmdIllegal,
    // data timing
    output logic rdDataValid,
    output logic [1:0] rdDataBank,
    output logic wrDataTaken,
    output logic [1:0] wrDataBank
);
    localparam int NBank = `SDBL_NBANK;
    localparam logic [`SDBL_CNT_W-1:0] RcLoad = `SDBL_CNT_W'(`SDBL_RC_CYC - 1);
    localparam logic [`SDBL_CNT_W-1:0] MrdLoad = `SDBL_CNT_W'(`SDBL_MRD_CYC - 1);
    localparam logic [`SDBL_CNT_W-1:0] RpLoad = `SDBL_CNT_W'(`SDBL_RP_CYC - 1);
    localparam logic [7:0] BurstLoad = 8'(BurstLen - 1);

    // ****************************************************
    // declarations
    // ****************************************************
    sdbl_bank_if bankIf [NBank] ();
    sdbl_pkg::sdbl_bank_e st [NBank];
    sdbl_pkg::sdbl_glob_e glob_r;
    logic [`SDBL_CNT_W-1:0] globCnt_r;
    logic [2:0] code;
    logic isAct, isRd, isWr, isPre, isRef, isLmr, isBst, isExec;
    logic tgtIdle, tgtOpen, anyIdleAll, allPreOk, legal;
    logic accAct, accRd, accWr, accPre, accRef, accLmr, accBst, accRw;
    logic burstOn_r, burstWr_r;
    logic [1:0] burstBank_r;
    logic [7:0] burstLeft_r;
    logic endNow, cutOther, cutDelayed, preHit, contBeat;
    logic [CasLatency-1:0] rdPipeV_r, stopPipeV_r;
    logic [1:0] rdPipeB_r [CasLatency];
    logic [1:0] stopPipeB_r [CasLatency];
    logic cmdIllegal_r, wrTaken_r;
    logic [1:0] wrBank_r;

    // ****************************************************
    // command decode
    // ****************************************************
    // select high is inhibit; the rest keyed on ras, cas, we
    assign code = {rasN, casN, weN};
    assign isExec = !csN && (code != `SDBL_CMD_NOP);
    assign isAct = isExec && (code == `SDBL_CMD_ACT);
    assign isRd = isExec && (code == `SDBL_CMD_RD);
    assign isWr = isExec && (code == `SDBL_CMD_WR);
    assign isPre = isExec && (code == `SDBL_CMD_PRE);
    assign isRef = isExec && (code == `SDBL_CMD_REF);
    assign isLmr = isExec && (code == `SDBL_CMD_LMR);
    assign isBst = isExec && (code == `SDBL_CMD_BST);

    // ****************************************************
    // bank array
    // ****************************************************
    genvar g;
    generate
        for (g = 0; g < NBank; g++) begin : gBank
            sdbl_bank uBank (
                .clock(clock),
                .reset_n(reset_n),
                .bus(bankIf[g].bank)
            );
            assign st[g] = bankIf[g].state;
            // only the addressed bank reacts, except that precharge with autoPre reaches every bank
            assign bankIf[g].act = accAct && (bankAddr == 2'(g));
            assign bankIf[g].rd = accRd && (bankAddr == 2'(g));
            assign bankIf[g].wr = accWr && (bankAddr == 2'(g));
            assign bankIf[g].ap = autoPre;
            assign bankIf[g].pre = accPre
                && (autoPre || (bankAddr == 2'(g)));
            // natural end, terminate, immediate cut or delayed cut
            assign bankIf[g].stop =
                ((endNow || accBst || cutOther) && burstBank_r == 2'(g))
                || (stopPipeV_r[CasLatency-1]
                    && stopPipeB_r[CasLatency-1] == 2'(g));
        end
    endgenerate

    // ****************************************************
    // packed bank view
    // ****************************************************
    // one process owns the whole status word
    always_comb begin
        for (int i = 0; i < NBank; i++) begin
            bankStates[8*i +: 8] = st[i];
        end
    end

    // ****************************************************
    // legality of the command against bank and device state
    // ****************************************************
    always_comb begin
        anyIdleAll = 1'b1;
        allPreOk = 1'b1;
        for (int i = 0; i < NBank; i++) begin
            if (st[i] != sdbl_pkg::BANK_IDLE) anyIdleAll = 1'b0;
            // every bank must be in a state open to precharge
            if (!(st[i] inside {sdbl_pkg::BANK_IDLE, sdbl_pkg::BANK_ACTIVE,
                    sdbl_pkg::BANK_READ, sdbl_pkg::BANK_WRITE}))
                allPreOk = 1'b0;
        end
    end

    assign tgtIdle = (st[bankAddr] == sdbl_pkg::BANK_IDLE);
    assign tgtOpen = st[bankAddr] inside {sdbl_pkg::BANK_ACTIVE,
        sdbl_pkg::BANK_READ, sdbl_pkg::BANK_WRITE};

    // anything outside the allowed set is refused and flagged
    always_comb begin
        legal = 1'b0;
        if (glob_r != sdbl_pkg::GLOB_NORMAL) legal = 1'b0;
        else if (isAct) legal = tgtIdle;
        else if (isRd || isWr) legal = tgtOpen;
        else if (isPre) legal = autoPre ? allPreOk : (tgtIdle || tgtOpen);
        else if (isRef || isLmr) legal = anyIdleAll;
        else if (isBst) legal = burstOn_r
            && (st[burstBank_r] inside {sdbl_pkg::BANK_READ,
                sdbl_pkg::BANK_WRITE});
    end

    assign accAct = isAct && legal;
    assign accRd = isRd && legal;
    assign accWr = isWr && legal;
    assign accPre = isPre && legal;
    assign accRef = isRef && legal;
    assign accLmr = isLmr && legal;
    assign accBst = isBst && legal;
    assign accRw = accRd || accWr;

    // ****************************************************
    // burst cut and end conditions
    // ****************************************************
    assign endNow = burstOn_r && (burstLeft_r == 8'h00)
        && !(accRw && bankAddr == burstBank_r);
    assign preHit = accPre && burstOn_r
        && (autoPre || bankAddr == burstBank_r);
    // a read cutting a plain read takes effect one latency later
    assign cutDelayed = !endNow && burstOn_r && accRd
        && bankAddr != burstBank_r
        && st[burstBank_r] == sdbl_pkg::BANK_READ;
    // every other cross-bank cut acts on the edge it is taken
    assign cutOther = !endNow && burstOn_r && accRw
        && bankAddr != burstBank_r && !cutDelayed;
    assign contBeat = burstOn_r && (burstLeft_r != 8'h00)
        && !accBst && !accRw && !preHit;

    // ****************************************************
    // most recent burst
    // ****************************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            burstOn_r <= 1'b0;
            burstWr_r <= 1'b0;
            burstBank_r <= 2'h0;
            burstLeft_r <= 8'h00;
        end else if (accRw) begin
            burstOn_r <= 1'b1;
            burstWr_r <= accWr;
            burstBank_r <= bankAddr;
            burstLeft_r <= BurstLoad;
        end else if (accBst || preHit || endNow) begin
            burstOn_r <= 1'b0;
        end else if (contBeat) begin
            burstLeft_r <= burstLeft_r - 8'h01;
        end
    end

    // ****************************************************
    // read data and delayed cut pipelines
    // ****************************************************
    // a write flushes queued read data; the mask covers the bus
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdPipeV_r <= '0;
            stopPipeV_r <= '0;
            for (int i = 0; i < CasLatency; i++) begin
                rdPipeB_r[i] <= 2'h0;
                stopPipeB_r[i] <= 2'h0;
            end
        end else begin
            rdPipeV_r[0] <= accRd || (contBeat && !burstWr_r);
            rdPipeB_r[0] <= accRd ? bankAddr : burstBank_r;
            stopPipeV_r[0] <= cutDelayed;
            stopPipeB_r[0] <= burstBank_r;
            for (int i = 1; i < CasLatency; i++) begin
                rdPipeV_r[i] <= rdPipeV_r[i-1] && !accWr;
                rdPipeB_r[i] <= rdPipeB_r[i-1];
                stopPipeV_r[i] <= stopPipeV_r[i-1];
                stopPipeB_r[i] <= stopPipeB_r[i-1];
            end
            if (accWr) rdPipeV_r[0] <= 1'b0;
        end
    end

    // ****************************************************
    // write data ownership
    // ****************************************************
    // data on the cutting edge already belongs to the new command
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            wrTaken_r <= 1'b0;
            wrBank_r <= 2'h0;
        end else begin
            wrTaken_r <= accWr || (contBeat && burstWr_r);
            wrBank_r <= accWr ? bankAddr : burstBank_r;
        end
    end

    // ****************************************************
    // device-wide states
    // ****************************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            glob_r <= sdbl_pkg::GLOB_NORMAL;
            globCnt_r <= '0;
        end else begin
            if (globCnt_r != '0) globCnt_r <= globCnt_r - `SDBL_CNT_W'(1);
            unique case (glob_r)
                sdbl_pkg::GLOB_NORMAL: begin
                    if (accRef) begin
                        glob_r <= sdbl_pkg::GLOB_REFRESH;
                        globCnt_r <= RcLoad;
                    end else if (accLmr) begin
                        glob_r <= sdbl_pkg::GLOB_MODE;
                        globCnt_r <= MrdLoad;
                    end else if (accPre && autoPre) begin
                        glob_r <= sdbl_pkg::GLOB_PRE_ALL;
                        globCnt_r <= RpLoad;
                    end
                end
                sdbl_pkg::GLOB_REFRESH, sdbl_pkg::GLOB_MODE,
                sdbl_pkg::GLOB_PRE_ALL: begin
                    if (globCnt_r <= `SDBL_CNT_W'(1))
                        glob_r <= sdbl_pkg::GLOB_NORMAL;
                end
                default: begin
                    glob_r <= sdbl_pkg::GLOB_NORMAL;
                end
            endcase
        end
    end

    // ****************************************************
    // status flag
    // ****************************************************
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) cmdIllegal_r <= 1'b0;
        else cmdIllegal_r <= isExec && !legal;
    end

    // ****************************************************
    // outputs
    // ****************************************************
    assign globalState = glob_r;
    assign allIdle = anyIdleAll && (glob_r == sdbl_pkg::GLOB_NORMAL);
    assign cmdIllegal = cmdIllegal_r;
    assign rdDataValid = rdPipeV_r[CasLatency-1];
    assign rdDataBank = rdPipeB_r[CasLatency-1];
    assign wrDataTaken = wrTaken_r;
    assign wrDataBank = wrBank_r;
endmodule : sdbl_legality

// ==== bench/sdbl_legality_sva.sv ====
// timing and legality checks on the four-bank command block
// assumes one clock domain and the block's own port names
`timescale 1ns/1ns
module sdbl_legality_sva #(
    parameter int CasLatency = 3,
    parameter int BurstLen = 4
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // command pins
    input wire logic csN,
    input wire logic rasN,
    input wire logic casN,
    input wire logic weN,
    input wire logic [1:0] bankAddr,
    input wire logic autoPre,
    // state view
    input wire logic [31:0] bankStates,
    input wire logic [3:0] globalState,
    input wire logic allIdle,
    input wire logic cmdIllegal,
    // data timing
    input wire logic rdDataValid,
    input wire logic [1:0] rdDataBank,
    input wire logic wrDataTaken,
    input wire logic [1:0] wrDataBank
);
    // deselect folds into nop so one code test covers both
    wire logic [2:0] cmd = csN ? 3'h7 : {rasN, casN, weN};
    wire logic [7:0] tgt = bankStates[8*bankAddr +: 8];
    wire logic normal = globalState == 4'h1;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    idle_view_a: assert property (
        allIdle == (bankStates == 32'h01010101 && normal))
        else $error("all-idle flag disagrees with bank view");
    act_opens_a: assert property (
        cmd == 3'h3 && tgt == 8'h01 && normal
        |=> bankStates[8*$past(bankAddr) +: 8] == 8'h02)
        else $error("activate did not open the bank");
    rfsh_len_a: assert property (
        cmd == 3'h1 && allIdle
        |=> (globalState == 4'h2) [*8] ##1 globalState == 4'h1)
        else $error("refresh span wrong");
    mode_len_a: assert property (
        cmd == 3'h0 && allIdle |=> globalState == 4'h4 ##1 normal)
        else $error("mode access span wrong");
    pre_all_len_a: assert property (
        cmd == 3'h2 && autoPre && normal
        && (bankStates & 32'he2e2e2e2) == 32'h0
        |=> (globalState == 4'h8) [*2] ##1 allIdle)
        else $error("precharge-all span wrong");
    rd_ap_a: assert property (
        cmd == 3'h5 && autoPre && normal && tgt == 8'h04
        |=> bankStates[8*$past(bankAddr) +: 8] == 8'h20)
        else $error("read with precharge state missing");
    pre_idle_a: assert property (
        cmd == 3'h2 && !autoPre && normal && tgt == 8'h01
        |=> bankStates[8*$past(bankAddr) +: 8] == 8'h01 && !cmdIllegal)
        else $error("precharge of idle bank had an effect");
    glob_refuse_a: assert property (
        cmd != 3'h7 && !normal
        |=> cmdIllegal && (bankStates & 32'h7e7e7e7e) == 32'h0)
        else $error("command in global state not refused");
    wr_take_a: assert property (
        cmd == 3'h4 && normal && (tgt & 8'h1c) != 8'h0
        |=> wrDataTaken && wrDataBank == $past(bankAddr))
        else $error("write data not taken by new bank");
endmodule : sdbl_legality_sva

bind sdbl_legality sdbl_legality_sva #(.CasLatency(CasLatency),
    .BurstLen(BurstLen)) u_sdbl_legality_sva (.clock(clock),
    .reset_n(reset_n), .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
    .bankAddr(bankAddr), .autoPre(autoPre), .bankStates(bankStates),
    .globalState(globalState), .allIdle(allIdle), .cmdIllegal(cmdIllegal),
    .rdDataValid(rdDataValid), .rdDataBank(rdDataBank),
    .wrDataTaken(wrDataTaken), .wrDataBank(wrDataBank));

// ==== bench/sdbl_ctrl_model.sv ====
// controller stand-in: one command on the pins while go is high
// assumes the bench keeps all timing and only asks for what it means
`timescale 1ns/1ns
module sdbl_ctrl_model (
    // clock
    input wire logic clock,
    // request
    input wire logic go,
    input wire logic [2:0] op,
    input wire logic [1:0] bank,
    input wire logic ap,
    // command pins
    output logic csN,
    output logic rasN,
    output logic casN,
    output logic weN,
    output logic [1:0] bankAddr,
    output logic autoPre
);
    logic [5:0] last_r = 6'h00;
    // deselected lines flip each cycle so stale values never pass
    always_ff @(posedge clock) begin
        last_r <= {rasN, casN, weN, bankAddr, autoPre};
    end
    // select low only on request, else inhibit
    always_comb begin
        csN = !go;
        {rasN, casN, weN, bankAddr, autoPre} = go ? {op, bank, ap} : ~last_r;
    end
endmodule : sdbl_ctrl_model

// ==== bench/test_sdbl_legality.sv ====
// directed bench for the bank legality block with a controller model
// assumes the design files and the checker are compiled first
`timescale 1ns/1ns
`include "sdbl_defs.svh"
module test_sdbl_legality;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic go = 1'b0;
    logic [2:0] op = 3'h7;
    logic [1:0] bank = 2'h0;
    logic ap = 1'b0;
    wire logic csN, rasN, casN, weN, autoPre;
    wire logic [1:0] bankAddr;
    logic [31:0] bankStates;
    logic [3:0] globalState;
    logic allIdle, cmdIllegal, rdDataValid, wrDataTaken;
    logic [1:0] rdDataBank, wrDataBank;
    int errors = 0;
    int checked = 0;

    sdbl_ctrl_model u_sdbl_ctrl_model (.clock(clock), .go(go), .op(op),
        .bank(bank), .ap(ap), .csN(csN), .rasN(rasN), .casN(casN),
        .weN(weN), .bankAddr(bankAddr), .autoPre(autoPre));
    sdbl_legality u_sdbl_legality (.clock(clock), .reset_n(reset_n),
        .csN(csN), .rasN(rasN), .casN(casN), .weN(weN),
        .bankAddr(bankAddr), .autoPre(autoPre), .bankStates(bankStates),
        .globalState(globalState), .allIdle(allIdle),
        .cmdIllegal(cmdIllegal), .rdDataValid(rdDataValid),
        .rdDataBank(rdDataBank), .wrDataTaken(wrDataTaken),
        .wrDataBank(wrDataBank));

    // 8 ns period
    initial begin
        forever #4 clock = ~clock;
    end

    // command held until the edge that takes it
    task automatic issue(input logic [2:0] c, input logic [1:0] b,
                         input logic a);
        go <= 1'b1;
        op <= c;
        bank <= b;
        ap <= a;
        @(posedge clock);
    endtask : issue
    task automatic idle(input int n);
        go <= 1'b0;
        repeat (n) @(posedge clock);
    endtask : idle
    // falling edge: the edge's updates have landed
    task automatic look();
        @(negedge clock);
    endtask : look
    task automatic cmp_v(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_v
    task automatic cmp_st(input logic [1:0] b, input logic [7:0] exp);
        cmp_v(bankStates[8*b +: 8], exp);
    endtask : cmp_st

    task automatic t_cuts();
        issue(`SDBL_CMD_ACT, 2'h0, 1'b0);
        look();
        cmp_st(2'h0, 8'h02);
        issue(`SDBL_CMD_ACT, 2'h1, 1'b0);
        idle(2);
        issue(`SDBL_CMD_RD, 2'h0, 1'b0);
        issue(`SDBL_CMD_RD, 2'h1, 1'b0);
        look();
        cmp_st(2'h0, 8'h08);
        idle(2);
        look();
        cmp_st(2'h0, 8'h08);
        cmp_v(8'({rdDataValid, rdDataBank}), 8'h05);
        idle(1);
        look();
        cmp_st(2'h0, 8'h04);
        idle(4);
        issue(`SDBL_CMD_WR, 2'h0, 1'b0);
        issue(`SDBL_CMD_WR, 2'h1, 1'b0);
        look();
        cmp_st(2'h0, 8'h04);
        cmp_v(8'(wrDataBank), 8'h01);
        issue(`SDBL_CMD_RD, 2'h0, 1'b0);
        look();
        cmp_st(2'h1, 8'h04);
        cmp_v(8'(wrDataTaken), 8'h00);
        issue(`SDBL_CMD_WR, 2'h1, 1'b0);
        look();
        cmp_st(2'h0, 8'h04);
        cmp_st(2'h1, 8'h10);
        issue(`SDBL_CMD_BST, 2'h0, 1'b0);
        look();
        cmp_st(2'h1, 8'h04);
        $display("burst cut test done");
    endtask : t_cuts

    task automatic t_auto_pre();
        issue(`SDBL_CMD_RD, 2'h0, 1'b1);
        look();
        cmp_st(2'h0, 8'h20);
        issue(`SDBL_CMD_RD, 2'h1, 1'b0);
        look();
        cmp_st(2'h0, 8'h20);
        idle(2);
        look();
        cmp_st(2'h0, 8'h01);
        idle(5);
        issue(`SDBL_CMD_PRE, 2'h0, 1'b0);
        look();
        cmp_st(2'h0, 8'h01);
        cmp_v(8'(cmdIllegal), 8'h00);
        issue(`SDBL_CMD_PRE, 2'h0, 1'b1);
        look();
        cmp_v(8'(globalState), 8'h08);
        issue(`SDBL_CMD_ACT, 2'h2, 1'b0);
        look();
        cmp_v(8'(cmdIllegal), 8'h01);
        idle(1);
        look();
        cmp_v(8'(allIdle), 8'h01);
        $display("precharge test done");
    endtask : t_auto_pre

    task automatic t_global();
        issue(`SDBL_CMD_REF, 2'h0, 1'b0);
        idle(7);
        look();
        cmp_v(8'(globalState), 8'h02);
        idle(1);
        look();
        cmp_v(8'(globalState), 8'h01);
        issue(`SDBL_CMD_LMR, 2'h0, 1'b0);
        look();
        cmp_v(8'(globalState), 8'h04);
        idle(1);
        issue(`SDBL_CMD_ACT, 2'h3, 1'b0);
        issue(`SDBL_CMD_REF, 2'h0, 1'b0);
        look();
        cmp_v(8'(cmdIllegal), 8'h01);
        cmp_v(8'(globalState), 8'h01);
        idle(1);
        $display("global state test done");
    endtask : t_global

    task automatic conclude();
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // main sequence after five reset cycles
    initial begin
        repeat (5) @(posedge clock);
        reset_n <= 1'b1;
        look();
        cmp_v(8'(allIdle), 8'h01);
        cmp_v(bankStates[31:24], 8'h01);
        t_cuts();
        t_auto_pre();
        t_global();
        conclude();
    end
    // run needs well under a thousand cycles
    initial begin
        #20000;
        errors++;
        $display("watchdog expired");
        conclude();
    end
endmodule : test_sdbl_legality
